/* hdl/touch_pkg.sv */
// package with constants and carriers for the touch detect processing block
package touch_pkg;
  localparam int          SIG_W          = 16;
  localparam int          CLK_HZ         = 20000000;
  // apb register map
  localparam logic [7:0]  CFG_OFS        = 8'h00;
  localparam logic [7:0]  SAMPLE_OFS     = 8'h04;
  localparam logic [7:0]  REF_OFS        = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0c;
  localparam logic [7:0]  DRIFT_OFS      = 8'h10;
  // status field positions
  localparam int          ST_DETECT      = 0;
  localparam int          ST_OUT         = 1;
  localparam int          ST_CAL         = 2;
  localparam int          ST_INTEG_LSB   = 4;
  localparam int          ST_MODE_LSB    = 8;
  localparam int          ST_PIN         = 10;
  // thresholds
  localparam logic [15:0] THR_HIGH_GAIN  = 16'h0006;
  localparam logic [15:0] THR_LOW_GAIN   = 16'h000c;
  localparam int          HYST_PCT       = 17;
  localparam logic [1:0]  INTEG_LIMIT    = 2'h3;
  // drift: bursts between reference steps, down is faster than up
  localparam logic [7:0]  DRIFT_UP_RST   = 8'h40;
  localparam logic [7:0]  DRIFT_DN_RST   = 8'h04;
  // timing
  localparam int          HEALTH_US      = 300;
  localparam int          HEALTH_CYC     = HEALTH_US * (CLK_HZ / 1000000);
  localparam int          MS_CYC         = CLK_HZ / 1000;
  localparam int          TIMEOUT_10_S   = 10;
  localparam int          TIMEOUT_60_S   = 60;
  localparam int          TIMEOUT_10_MS  = TIMEOUT_10_S * 1000;
  localparam int          TIMEOUT_60_MS  = TIMEOUT_60_S * 1000;

  typedef enum logic [1:0] {
    MODE_LEVEL_10  = 2'h0,
    MODE_LEVEL_60  = 2'h1,
    MODE_TOGGLE_10 = 2'h2,
    MODE_LEVEL_INF = 2'h3
  } out_mode_e;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_RECAL   = 3'b010,
    ST_SENSE   = 3'b100
  } cal_state_e;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
endpackage

/* hdl/touch_detect.sv */
// touch detect processing: reference tracking, integrator, timeout and output
// Behaviour
// - all signal, reference, threshold and hysteresis math uses 16 bits; the hysteresis percentage is worked out in 32 bits and then cut to 16
// - with no detection the reference slowly slews toward the signal
// - threshold and hysteresis are fixed offsets riding on the reference
// - during a detection the reference is frozen
// - reference falls toward a lower signal faster than it rises
// - gain strap high gives 6 counts threshold, low gives 12 counts
// - detection ends when signal drops 17 percent of threshold below it
// - detection longer than a finite timeout forces full recalibration
// - three successive detecting bursts activate output, a miss clears count
// - no recalibration input, full recalibration at power-up and after a detection timeout
// - straps sampled only at power-up, later changes ignored
// - option straps pick level 10s, level 60s, toggle 10s or level infinite
// - level mode holds output low until detection ends or timeout
// - level mode timeout recalibrates and drives output high until next touch
// - toggle mode inverts on each confirmed touch, timeout keeps state
// - after every burst output floats for 300 us as a health pulse
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`default_nettype none
module touch_detect
  import touch_pkg::*;
(
  // clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RSTN,
  // straps from pins
  input  wire logic               OPTION_STRAP_A,
  input  wire logic               OPTION_STRAP_B,
  input  wire logic               GAIN_STRAP,
  // burst result from the acquisition front end
  input  wire logic               BURST_DONE,
  input  wire logic [SIG_W-1:0]   BURST_SIGNAL,
  // apb slave
  input  wire touch_pkg::apb_req_s APB_REQ,
  output touch_pkg::apb_rsp_s     APB_RSP,
  // active low touch output as three signals
  input  wire logic               TOUCH_N_IN,
  output logic                    TOUCH_N_OUT,
  output logic                    TOUCH_N_OE_N
);
  import touch_pkg::*;

  // synchronisers and burst strobe
  logic [2:0]       strap_meta;
  logic [2:0]       strap_sync;
  logic [1:0]       done_sync;
  logic             done_prev;
  logic             burst_pulse;
  logic [1:0]       pin_sync;
  // sample, reference and the levels derived from it
  logic [SIG_W-1:0] sample;
  logic [SIG_W-1:0] reference;
  logic [SIG_W-1:0] threshold;
  logic [SIG_W-1:0] hysteresis;
  logic [SIG_W-1:0] thr_level;
  logic [SIG_W-1:0] drop_level;
  logic [SIG_W-1:0] raw_delta;
  logic             over_thr;
  logic             above_drop;
  // configuration, calibration and detection state
  out_mode_e        mode;
  cal_state_e       cal_state;
  logic [1:0]       integ;
  logic             detect;
  logic             out_active;
  // drift rates and their burst counters
  logic [7:0]       drift_up_div;
  logic [7:0]       drift_dn_div;
  logic [7:0]       drift_up_cnt;
  logic [7:0]       drift_dn_cnt;
  // time base, on-duration timer and health pulse
  logic [14:0]      ms_cnt;
  logic             ms_tick;
  logic [16:0]      on_ms;
  logic [16:0]      limit_ms;
  logic             timed_out;
  logic [12:0]      health_cnt;
  // register bus
  logic             apb_access;
  logic [31:0]      next_rdata;
  logic [31:0]      rdata;

  // synchronise straps and burst strobe that come from outside the clock
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      done_sync  <= 2'h0;
      done_prev  <= 1'b0;
    end else begin
      strap_meta <= {GAIN_STRAP, OPTION_STRAP_B, OPTION_STRAP_A};
      strap_sync <= strap_meta;
      done_sync  <= {done_sync[0], BURST_DONE};
      done_prev  <= done_sync[1];
    end
  end
  // one-cycle strobe on the rising edge of the synchronised burst flag
  assign burst_pulse = done_sync[1] & ~done_prev;

  // pin readback passes two flip-flops; a plain delay line needs no reset
  always_ff @(posedge CORE_CLK) begin
    pin_sync <= {pin_sync[0], TOUCH_N_IN};
  end

  // power-up sequencing: straps settle, then a full recalibration, then sensing
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      cal_state <= ST_POWERUP;
      mode      <= MODE_LEVEL_10;
      threshold <= THR_LOW_GAIN;
    end else begin
      case (cal_state)
        ST_POWERUP: begin
          if (burst_pulse) begin // straps are past both sync stages by now
            cal_state <= ST_RECAL;
            case ({strap_sync[0], strap_sync[1]})
              2'b11:   mode <= MODE_LEVEL_10;
              2'b10:   mode <= MODE_LEVEL_60;
              2'b00:   mode <= MODE_TOGGLE_10;
              default: mode <= MODE_LEVEL_INF;
            endcase
            threshold <= strap_sync[2] ? THR_HIGH_GAIN : THR_LOW_GAIN;
          end
        end
        ST_RECAL: begin
          if (burst_pulse) begin
            cal_state <= ST_SENSE;
          end
        end
        ST_SENSE: begin
          if (timed_out) begin
            cal_state <= ST_RECAL;
          end
        end
        default: cal_state <= ST_POWERUP;
      endcase
    end
  end

  // capture one sample per burst
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sample <= 16'h0000;
    end else if (burst_pulse) begin
      sample <= BURST_SIGNAL;
    end
  end

  // threshold and hysteresis levels hang off the reference
  assign hysteresis = 16'((32'(threshold) * HYST_PCT + 32'd99) / 32'd100);
  assign thr_level  = reference + threshold;
  assign drop_level = thr_level - hysteresis;
  assign raw_delta  = BURST_SIGNAL - reference;
  assign over_thr   = (BURST_SIGNAL > reference) && (raw_delta >= threshold);
  assign above_drop = BURST_SIGNAL >= drop_level;

  // reference: set at recalibration, drift only while idle, asymmetric rates
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      reference    <= 16'h0000;
      drift_up_cnt <= 8'h00;
      drift_dn_cnt <= 8'h00;
    end else if (burst_pulse) begin
      if (cal_state != ST_SENSE) begin
        reference    <= BURST_SIGNAL;
        drift_up_cnt <= 8'h00;
        drift_dn_cnt <= 8'h00;
      end else if (!detect && integ == 2'h0) begin
        if (BURST_SIGNAL > reference) begin
          drift_dn_cnt <= 8'h00;
          if (drift_up_cnt + 8'h01 >= drift_up_div) begin
            drift_up_cnt <= 8'h00;
            reference    <= reference + 16'h0001;
          end else begin
            drift_up_cnt <= drift_up_cnt + 8'h01;
          end
        end else if (BURST_SIGNAL < reference) begin
          drift_up_cnt <= 8'h00;
          if (drift_dn_cnt + 8'h01 >= drift_dn_div) begin
            drift_dn_cnt <= 8'h00;
            reference    <= reference - 16'h0001;
          end else begin
            drift_dn_cnt <= drift_dn_cnt + 8'h01;
          end
        end
      end
    end
  end

  // detection integrator and hysteresis release
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      integ  <= 2'h0;
      detect <= 1'b0;
    end else if (cal_state != ST_SENSE || timed_out) begin
      integ  <= 2'h0;
      detect <= 1'b0;
    end else if (burst_pulse) begin
      if (detect) begin
        detect <= above_drop;
        integ  <= 2'h0;
      end else if (over_thr) begin
        if (integ + 2'h1 >= INTEG_LIMIT) begin
          detect <= 1'b1;
          integ  <= 2'h0;
        end else begin
          integ <= integ + 2'h1;
        end
      end else begin
        integ <= 2'h0;
      end
    end
  end

  // millisecond time base for the on-duration timer
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ms_cnt <= 15'h0000;
    end else if (ms_cnt == 15'(MS_CYC - 1)) begin
      ms_cnt <= 15'h0000;
    end else begin
      ms_cnt <= ms_cnt + 15'h0001;
    end
  end
  assign ms_tick = (ms_cnt == 15'(MS_CYC - 1));

  // on-duration timer runs while a detection is in effect
  always_comb begin
    case (mode)
      MODE_LEVEL_60: limit_ms = 17'(TIMEOUT_60_MS);
      default:       limit_ms = 17'(TIMEOUT_10_MS);
    endcase
  end
  // the infinite mode never times out
  assign timed_out = detect && (mode != MODE_LEVEL_INF) && (on_ms >= limit_ms);

  // milliseconds of the current detection, restarted whenever it ends
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      on_ms <= 17'h00000;
    end else if (!detect || timed_out) begin
      on_ms <= 17'h00000;
    end else if (ms_tick && on_ms != 17'h1ffff) begin
      on_ms <= on_ms + 17'h00001;
    end
  end

  // output state: level follows detection, toggle flips on each confirmation
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      out_active <= 1'b0;
    end else if (mode == MODE_TOGGLE_10) begin
      if (burst_pulse && cal_state == ST_SENSE && !detect && !timed_out && over_thr &&
          integ + 2'h1 >= INTEG_LIMIT) begin
        out_active <= ~out_active;
      end
    end else if (timed_out) begin
      out_active <= 1'b0;
    end else begin
      out_active <= detect;
    end
  end

  // health pulse: float the pin for a fixed time after every burst
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      health_cnt <= 13'h0000;
    end else if (burst_pulse) begin
      health_cnt <= 13'(HEALTH_CYC);
    end else if (health_cnt != 13'h0000) begin
      health_cnt <= health_cnt - 13'h0001;
    end
  end

  // pin drive, low means touched; floated while the health pulse runs
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      TOUCH_N_OUT  <= 1'b1;
      TOUCH_N_OE_N <= 1'b0;
    end else begin
      TOUCH_N_OUT  <= ~out_active;
      TOUCH_N_OE_N <= (health_cnt != 13'h0000);
    end
  end

  // apb: writable drift rates, read-only sample, reference and status
  assign apb_access = APB_REQ.psel && APB_REQ.penable;

  // drift divider write; a zero is taken as one, which steps on every burst just as a zero would
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      drift_up_div <= DRIFT_UP_RST;
      drift_dn_div <= DRIFT_DN_RST;
    end else if (apb_access && APB_REQ.pwrite && APB_REQ.paddr == DRIFT_OFS) begin
      drift_up_div <= (APB_REQ.pwdata[15:8] == 8'h00) ? 8'h01 : APB_REQ.pwdata[15:8];
      drift_dn_div <= (APB_REQ.pwdata[7:0] == 8'h00) ? 8'h01 : APB_REQ.pwdata[7:0];
    end
  end

  // read decode
  always_comb begin
    next_rdata = 32'h00000000;
    if (APB_REQ.paddr == CFG_OFS) begin
      next_rdata = {16'h0000, threshold};
    end else if (APB_REQ.paddr == SAMPLE_OFS) begin
      next_rdata = {16'h0000, sample};
    end else if (APB_REQ.paddr == REF_OFS) begin
      next_rdata = {16'h0000, reference};
    end else if (APB_REQ.paddr == STATUS_OFS) begin
      next_rdata[ST_DETECT]                 = detect;
      next_rdata[ST_OUT]                    = out_active;
      next_rdata[ST_CAL]                    = (cal_state != ST_SENSE);
      next_rdata[ST_INTEG_LSB +: 2]         = integ;
      next_rdata[ST_MODE_LSB +: 2]          = mode;
      next_rdata[ST_PIN]                    = pin_sync[1];
    end else if (APB_REQ.paddr == DRIFT_OFS) begin
      next_rdata = {16'h0000, drift_up_div, drift_dn_div};
    end
  end

  // read data is taken in the setup cycle so that prdata comes from a flip-flop;
  // it shows the state one cycle before the access edge
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rdata <= 32'h00000000;
    end else if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
      rdata <= next_rdata;
    end
  end

  // zero-wait answer; unmapped addresses give an error
  always_comb begin
    APB_RSP.pready  = 1'b1;
    APB_RSP.prdata  = rdata;
    APB_RSP.pslverr = apb_access && !(APB_REQ.paddr == CFG_OFS ||
                      APB_REQ.paddr == SAMPLE_OFS || APB_REQ.paddr == REF_OFS ||
                      APB_REQ.paddr == STATUS_OFS || APB_REQ.paddr == DRIFT_OFS);
  end

endmodule
`default_nettype wire

/* dv/touch_load_model.sv */
// pull-down load on the touch pin that counts health pulses
`default_nettype none
module touch_load_model (
  // pin side
  input  wire logic out_val,
  input  wire logic oe_n,
  output logic      pin,
  // monitor count
  output int        pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pin is pulled low by the load
  assign pin = oe_n ? 1'b0 : out_val;
  // count low-going edges as health pulses
  initial pulses = 0;
  always @(negedge pin) pulses++;
endmodule
`default_nettype wire

/* dv/touch_detect_properties.sv */
// port checker for the touch detect block
`default_nettype none
module touch_detect_properties (
  // clock and reset
  input wire logic                CORE_CLK,
  input wire logic                RSTN,
  // burst and apb
  input wire logic                BURST_DONE,
  input wire touch_pkg::apb_req_s APB_REQ,
  input wire touch_pkg::apb_rsp_s APB_RSP,
  // touch pin
  input wire logic                TOUCH_N_IN,
  input wire logic                TOUCH_N_OUT,
  input wire logic                TOUCH_N_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  import touch_pkg::*;
  logic [7:0]  since;
  logic [15:0] hi_cnt;
  logic        acc;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // access phase of an apb transfer
  assign acc = APB_REQ.psel && APB_REQ.penable;
  // cycles since the last burst began, saturating
  always_ff @(posedge CORE_CLK)
    if (!RSTN || $rose(BURST_DONE)) since <= 8'h00;
    else if (since != 8'hff) since <= since + 8'h01;
  // length of the current float interval
  always_ff @(posedge CORE_CLK)
    if (!RSTN || !TOUCH_N_OE_N) hi_cnt <= 16'h0000;
    else hi_cnt <= hi_cnt + 16'h0001;
  chk_apb_no_wait: assert property (acc |-> APB_RSP.pready)
    else $error("apb access without ready");
  chk_bad_addr: assert property (acc && APB_REQ.paddr > DRIFT_OFS |-> APB_RSP.pslverr)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (acc && APB_REQ.paddr <= DRIFT_OFS
    && APB_REQ.paddr[1:0] == 2'h0 |-> !APB_RSP.pslverr) else $error("mapped access refused");
  chk_pin_readback: assert property (acc && !APB_REQ.pwrite && APB_REQ.paddr == STATUS_OFS
    |-> APB_RSP.prdata[ST_PIN] == $past(TOUCH_N_IN, 3)) else $error("pin readback wrong");
  chk_release_idle: assert property ($rose(RSTN) |-> TOUCH_N_OUT && !TOUCH_N_OE_N)
    else $error("output not idle after reset");
  chk_float_width: assert property ($fell(TOUCH_N_OE_N) |-> hi_cnt >= HEALTH_CYC)
    else $error("health float too short");
  chk_float_cause: assert property ($rose(TOUCH_N_OE_N) |-> since <= 8'h0c)
    else $error("float without burst");
  chk_touch_cause: assert property ($fell(TOUCH_N_OUT) |-> since <= 8'h0c)
    else $error("touch without burst");
endmodule
bind touch_detect touch_detect_properties touch_detect_properties_i (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .BURST_DONE(BURST_DONE), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .TOUCH_N_IN(TOUCH_N_IN), .TOUCH_N_OUT(TOUCH_N_OUT),
  .TOUCH_N_OE_N(TOUCH_N_OE_N)
);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the touch detect block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        opt_a = 1'b1;
  logic        opt_b = 1'b1;
  logic        gain = 1'b1;
  logic        bdone = 1'b0;
  logic [15:0] bsig = 16'h0000;
  apb_req_s    req = '0;
  apb_rsp_s    rsp;
  logic        pin;
  logic        out_n;
  logic        oe_n;
  logic [31:0] rd;
  logic        err;
  int          pulses;
  int          mismatches = 0;
  int          check_count = 0;
  // device and pin load
  touch_detect touch_detect_i (.CORE_CLK(clk), .RSTN(rstn), .OPTION_STRAP_A(opt_a),
    .OPTION_STRAP_B(opt_b), .GAIN_STRAP(gain), .BURST_DONE(bdone), .BURST_SIGNAL(bsig),
    .APB_REQ(req), .APB_RSP(rsp), .TOUCH_N_IN(pin), .TOUCH_N_OUT(out_n), .TOUCH_N_OE_N(oe_n));
  touch_load_model touch_load_model_i (.out_val(out_n), .oe_n(oe_n), .pin(pin), .pulses(pulses));
  // 20 mhz clock
  initial forever #25 clk = ~clk;
  // compare one value
  task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // one acquisition burst with its sample
  task automatic burst(input logic [15:0] v);
    @(posedge clk);
    bsig <= v;
    bdone <= 1'b1;
    repeat (6) @(posedge clk);
    bdone <= 1'b0;
    repeat (24) @(posedge clk);
  endtask
  // wait until the pin is driven again
  task automatic quiet();
    while (oe_n !== 1'b0) @(posedge clk);
  endtask
  // reset with straps, then configuring and reference bursts
  task automatic power(input logic a, input logic b, input logic g, input logic [15:0] r);
    @(posedge clk);
    rstn <= 1'b0;
    opt_a <= a;
    opt_b <= b;
    gain <= g;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    burst(r);
    burst(r);
  endtask
  // level mode: threshold, integrator, hysteresis, freeze, health pulse
  task automatic t_level();
    int p;
    int n;
    power(1'b1, 1'b1, 1'b1, 16'h03e8);
    apb(1'b0, CFG_OFS, 32'h0);
    check("threshold", THR_HIGH_GAIN, rd[15:0]);
    apb(1'b0, DRIFT_OFS, 32'h0);
    check("drift reset", 16'h4004, rd[15:0]);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", 16'h0001, 16'(err));
    burst(16'h03ed);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("below thr", 16'h0000, 16'(rd[ST_DETECT]));
    check("calibrating", 16'h0000, 16'(rd[ST_CAL]));
    check("pin floated", 16'h0000, 16'(rd[ST_PIN]));
    apb(1'b0, SAMPLE_OFS, 32'h0);
    check("sample", 16'h03ed, rd[15:0]);
    burst(16'h03ee);
    burst(16'h03ee);
    burst(16'h03e8);
    burst(16'h03ee);
    burst(16'h03ee);
    check("two counts", 16'h0001, 16'(out_n));
    apb(1'b0, STATUS_OFS, 32'h0);
    check("integ two", 16'h0002, 16'(rd[ST_INTEG_LSB +: 2]));
    burst(16'h03ee);
    check("confirmed", 16'h0000, 16'(out_n));
    apb(1'b0, STATUS_OFS, 32'h0);
    check("out bit", 16'h0001, 16'(rd[ST_OUT]));
    apb(1'b1, DRIFT_OFS, 32'h0101);
    burst(16'h03ec);
    check("held", 16'h0000, 16'(out_n));
    apb(1'b0, REF_OFS, 32'h0);
    check("ref frozen", 16'h03e8, rd[15:0]);
    quiet();
    p = pulses;
    burst(16'h03ec);
    quiet();
    check("no pulse low", 16'(p), 16'(pulses));
    burst(16'h03eb);
    check("released", 16'h0001, 16'(out_n));
    quiet();
    p = pulses;
    @(posedge clk);
    bsig <= 16'h03e8;
    bdone <= 1'b1;
    while (oe_n !== 1'b1) @(posedge clk);
    n = 0;
    while (oe_n === 1'b1) begin
      @(posedge clk);
      n++;
    end
    bdone <= 1'b0;
    check("float len", 16'(HEALTH_CYC), 16'(n));
    check("pulse idle", 16'(p + 1), 16'(pulses));
    $display("level test done");
  endtask
  // drift: slow tracking, falls faster than it rises
  task automatic t_drift();
    logic [15:0] r0;
    logic [15:0] r1;
    logic [15:0] r2;
    apb(1'b1, DRIFT_OFS, 32'h0201);
    apb(1'b0, DRIFT_OFS, 32'h0);
    check("drift rw", 16'h0201, rd[15:0]);
    apb(1'b0, REF_OFS, 32'h0);
    r0 = rd[15:0];
    repeat (4) burst(r0 - 16'h0064);
    apb(1'b0, REF_OFS, 32'h0);
    r1 = rd[15:0];
    check("ref falls", 16'h0001, 16'(r1 < r0 && r1 > r0 - 16'h0064));
    repeat (4) burst(r1 + 16'h0003);
    apb(1'b0, REF_OFS, 32'h0);
    r2 = rd[15:0];
    check("ref rises", 16'h0001, 16'(r2 > r1 && r2 - r1 < r0 - r1));
    $display("drift test done");
  endtask
  // toggle mode at low gain, later strap changes ignored
  task automatic t_toggle();
    power(1'b0, 1'b0, 1'b0, 16'h07d0);
    apb(1'b0, CFG_OFS, 32'h0);
    check("low gain", THR_LOW_GAIN, rd[15:0]);
    opt_a <= 1'b1;
    opt_b <= 1'b1;
    gain <= 1'b1;
    repeat (3) burst(16'h07dc);
    check("toggle on", 16'h0000, 16'(out_n));
    burst(16'h07d9);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("hyst hold", 16'h0001, 16'(rd[ST_DETECT]));
    burst(16'h07d8);
    apb(1'b0, STATUS_OFS, 32'h0);
    check("hyst end", 16'h0000, 16'(rd[ST_DETECT]));
    check("toggle kept", 16'h0000, 16'(out_n));
    repeat (3) burst(16'h07dc);
    check("toggle off", 16'h0001, 16'(out_n));
    apb(1'b0, STATUS_OFS, 32'h0);
    check("mode kept", 16'(MODE_TOGGLE_10), 16'(rd[ST_MODE_LSB +: 2]));
    $display("toggle test done");
  endtask
  // every strap pair selects its mode
  task automatic t_modes();
    logic [1:0] ab[4];
    out_mode_e  em[4];
    ab = '{2'b11, 2'b10, 2'b00, 2'b01};
    em = '{MODE_LEVEL_10, MODE_LEVEL_60, MODE_TOGGLE_10, MODE_LEVEL_INF};
    for (int i = 0; i < 4; i++) begin
      power(ab[i][1], ab[i][0], 1'b1, 16'h0100);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("mode", 16'(em[i]), 16'(rd[ST_MODE_LSB +: 2]));
    end
    $display("mode test done");
  endtask
  // report counts and end the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    t_level();
    t_drift();
    t_toggle();
    t_modes();
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
